// ### logic/msc_regs.sv
/*
 * msc_regs: status and control register bank of the motor controller.
 * assumes: host port is a word-indexed single-cycle read/write port from the
 * serial front end on the same clock; status sources are on the same clock.
 */
// Notes on behaviour
// [R1] host leaves undefined offsets untouched
// [R2] voltage magnitude in status bits 31-16
// [R3] decoded speed command in bits 15-4
// [R4] bit 3 high once nvm copy done
// [R5] bit 2 high once host may control
// [R6] resistance, backemf, inductance bytes reported
// [R7] four measurement status bits 31-28
// [R8] measurement pwm frequency in bits 27-24
// [R9] bit 31 requests nvm save
// [R10] bit 30 requests nvm load
// [R11] bit 29 clears latched faults
// [R12] bit 28 clears retry counter
// [R13] align angle bits 19-11 modulo 360
// [R14] host kicks watchdog every interval
// [R15] device clears the kick bit itself
// [R16] all words reset to zero
// [R17] writes to read-only fields ignored
// [R18] source select picks word or configured angle
// [R19] align hold keeps align state
// [R20] watchdog expiry sets fault bit 3
`timescale 1ns/1ps
module msc_regs #(
    parameter int WDOG_W = 24 // watchdog counter width
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset, high
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_idx, // register index
    input wire logic [31:0] reg_wdata, // write data
    output logic [31:0] reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid pulse
    input wire logic [15:0] applied_voltage_magnitude, // voltage magnitude
    input wire logic [11:0] duty_command, // decoded speed command
    input wire logic init_complete_flag, // nvm copy finished
    input wire logic host_control_ready_flag, // defaults copied
    input wire logic [7:0] meas_resistance, // measured resistance
    input wire logic [7:0] measured_backemf_constant, // measured backemf
    input wire logic [7:0] meas_inductance, // measured inductance
    input wire logic [3:0] meas_status, // r,l,ke,mech status
    input wire logic [3:0] meas_pwm_frequency, // pwm select during ke
    input wire logic [WDOG_W-1:0] host_watchdog_interval, // cycles, 0 = off
    input wire logic serial_mode, // serial speed control active
    input wire logic nvm_done, // nvm operation finished
    input wire logic [8:0] cfg_align_deg, // configured align angle
    input wire logic align_angle_source_select, // 1 = control word angle
    input wire logic align_hold_en, // forced align enable
    input wire logic align_startup, // startup mode uses align
    input wire logic align_done, // align time elapsed
    output logic nvm_save_busy, // save running
    output logic nvm_load_busy, // load running
    output logic fault_clear, // fault clear pulse
    output logic retry_count_clear, // retry clear pulse
    output logic [8:0] align_deg, // applied align angle
    output logic align_exit, // leave align state
    output logic watchdog_fault // latched watchdog fault
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    logic [31:0] st0_ff, st1_ff, st2_ff; // sampled status words
    logic [31:0] nxt_st0, nxt_st1, nxt_st2;
    logic [8:0] ang_ff, nxt_ang; // forced align angle field
    logic kick_ff, nxt_kick; // watchdog kick bit
    logic fclr_ff, nxt_fclr; // fault clear pulse
    logic rclr_ff, nxt_rclr; // retry clear pulse
    logic [WDOG_W-1:0] wd_ff, nxt_wd; // watchdog counter
    logic wdf_ff, nxt_wdf; // watchdog fault
    logic [31:0] rd_ff, nxt_rd; // read data
    logic rv_ff, nxt_rv; // read valid
    logic ctl_wr; // write to control word
    msc_nvm_if nv(); // nvm request link
    // ----------------------------------------------------------
    // nvm sequencer and angle selection
    // ----------------------------------------------------------
    msc_nvm_seq u_nvm (
        .clk(clk),
        .srst(srst),
        .nv(nv.seq),
        .nvm_done(nvm_done)
    );
    msc_angle_sel u_ang (
        .host_deg(ang_ff),
        .cfg_deg(cfg_align_deg),
        .src_sel(align_angle_source_select),
        .deg_out(align_deg)
    );
    assign ctl_wr = reg_wr && (reg_idx == msc_pkg::IDX_DEV_CTRL);
    assign nv.save_req = ctl_wr && reg_wdata[msc_pkg::CTL_NVM_SAVE]; // [R9]
    assign nv.load_req = ctl_wr && reg_wdata[msc_pkg::CTL_NVM_LOAD]; // [R10]
    // ----------------------------------------------------------
    // status sampling; writes never reach these words
    // ----------------------------------------------------------
    always_comb begin
        nxt_st0 = {applied_voltage_magnitude, // [R2]
            duty_command, // [R3]
            init_complete_flag, // [R4]
            host_control_ready_flag, // [R5]
            2'b00};
        nxt_st1 = {meas_resistance, measured_backemf_constant, meas_inductance, 8'h00}; // [R6]
        nxt_st2 = {meas_status, meas_pwm_frequency, 24'h000000}; // [R7] [R8]
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            st0_ff <= msc_pkg::RST_WORD; // [R16]
            st1_ff <= msc_pkg::RST_WORD;
            st2_ff <= msc_pkg::RST_WORD;
        end else begin
            st0_ff <= nxt_st0; // [R17]
            st1_ff <= nxt_st1;
            st2_ff <= nxt_st2;
        end
    end
    // ----------------------------------------------------------
    // control word; reserved bits are not stored
    // ----------------------------------------------------------
    always_comb begin
        nxt_ang = ang_ff;
        nxt_kick = kick_ff;
        nxt_fclr = 1'b0;
        nxt_rclr = 1'b0;
        if (kick_ff) begin
            nxt_kick = 1'b0; // [R15]
        end
        if (ctl_wr) begin
            nxt_ang = reg_wdata[msc_pkg::CTL_ANG_HI:msc_pkg::CTL_ANG_LO]; // [R13]
            nxt_kick = reg_wdata[msc_pkg::CTL_KICK]; // [R14]
            nxt_fclr = reg_wdata[msc_pkg::CTL_FLT_CLR]; // [R11]
            nxt_rclr = reg_wdata[msc_pkg::CTL_RETRY_CLR]; // [R12]
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            ang_ff <= 9'h000;
            kick_ff <= 1'b0;
            fclr_ff <= 1'b0;
            rclr_ff <= 1'b0;
        end else begin
            ang_ff <= nxt_ang;
            kick_ff <= nxt_kick;
            fclr_ff <= nxt_fclr;
            rclr_ff <= nxt_rclr;
        end
    end
    // ----------------------------------------------------------
    // host watchdog; expiry beats a same-cycle fault clear
    // ----------------------------------------------------------
    always_comb begin
        nxt_wd = wd_ff;
        nxt_wdf = wdf_ff;
        if (!serial_mode || host_watchdog_interval == '0 || kick_ff) begin
            nxt_wd = '0;
        end else if (wd_ff >= host_watchdog_interval - 1'b1) begin
            nxt_wd = '0;
        end else begin
            nxt_wd = wd_ff + 1'b1;
        end
        if (fclr_ff) begin
            nxt_wdf = 1'b0;
        end
        if (serial_mode && host_watchdog_interval != '0 && !kick_ff
            && wd_ff >= host_watchdog_interval - 1'b1) begin
            nxt_wdf = 1'b1; // [R20]
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            wd_ff <= '0;
            wdf_ff <= 1'b0;
        end else begin
            wd_ff <= nxt_wd;
            wdf_ff <= nxt_wdf;
        end
    end
    // ----------------------------------------------------------
    // read mux; unmapped and reserved indices read zero
    // ----------------------------------------------------------
    always_comb begin
        nxt_rv = reg_rd;
        nxt_rd = rd_ff;
        if (reg_rd) begin
            unique case (reg_idx)
                msc_pkg::IDX_SYS_STATUS: nxt_rd = st0_ff;
                msc_pkg::IDX_MOTOR_PARAMS: nxt_rd = st1_ff;
                msc_pkg::IDX_MEAS_STATUS: nxt_rd = st2_ff;
                msc_pkg::IDX_DEV_CTRL: begin
                    nxt_rd = msc_pkg::RST_WORD;
                    nxt_rd[msc_pkg::CTL_NVM_SAVE] = nv.busy_save;
                    nxt_rd[msc_pkg::CTL_NVM_LOAD] = nv.busy_load;
                    nxt_rd[msc_pkg::CTL_KICK] = kick_ff;
                end
                msc_pkg::IDX_CTRL_FAULT: begin
                    nxt_rd = msc_pkg::RST_WORD;
                    nxt_rd[msc_pkg::FLT_WDOG] = wdf_ff;
                end
                default: nxt_rd = msc_pkg::RST_WORD;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_ff <= msc_pkg::RST_WORD;
            rv_ff <= 1'b0;
        end else begin
            rd_ff <= nxt_rd;
            rv_ff <= nxt_rv;
        end
    end
    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign reg_rdata = rd_ff;
    assign reg_rvalid = rv_ff;
    assign nvm_save_busy = nv.busy_save;
    assign nvm_load_busy = nv.busy_load;
    assign fault_clear = fclr_ff;
    assign retry_count_clear = rclr_ff;
    assign watchdog_fault = wdf_ff;
    assign align_exit = align_done && !(align_hold_en && align_startup); // [R19]
endmodule // msc_regs

// ### logic/msc_pkg.sv
/*
 * msc_pkg: constants shared by the motor status and control register block.
 * assumes: registers are reached by word index on a plain read/write port.
 */
package msc_pkg;
    // --------------------------------------------------------------
    // register indices (words step by two, not by four)
    // --------------------------------------------------------------
    localparam logic [7:0] IDX_SYS_STATUS = 8'hE4; // algorithm_status
    localparam logic [7:0] IDX_MOTOR_PARAMS = 8'hE6; // measured_motor_params
    localparam logic [7:0] IDX_MEAS_STATUS = 8'hE8; // param_measure_status
    localparam logic [7:0] IDX_DEV_CTRL = 8'hEA; // device_control
    localparam logic [7:0] IDX_CTRL_FAULT = 8'hE2; // controller fault status
    // --------------------------------------------------------------
    // control word field positions
    // --------------------------------------------------------------
    localparam int CTL_NVM_SAVE = 31; // nvm_save_request
    localparam int CTL_NVM_LOAD = 30; // nvm load request
    localparam int CTL_FLT_CLR = 29; // fault_clear
    localparam int CTL_RETRY_CLR = 28; // retry_count_clear
    localparam int CTL_ANG_HI = 19; // forced align angle msb
    localparam int CTL_ANG_LO = 11; // forced align angle lsb
    localparam int CTL_KICK = 10; // watchdog kick
    localparam int FLT_WDOG = 3; // watchdog fault bit in fault word
    localparam logic [31:0] RST_WORD = 32'h00000000; // reset of all words
    localparam logic [8:0] DEG_360 = 9'h168; // angle modulus
endpackage

// ### logic/msc_nvm_if.sv
/*
 * msc_nvm_if: request and busy lines between the bank and its nvm sequencer.
 * assumes: one clock domain.
 */
`timescale 1ns/1ps
interface msc_nvm_if;
    logic save_req; // one-cycle save request
    logic load_req; // one-cycle load request
    logic busy_save; // save in progress
    logic busy_load; // load in progress
    modport bank (output save_req, output load_req, input busy_save, input busy_load);
    modport seq (input save_req, input load_req, output busy_save, output busy_load);
endinterface

// ### logic/msc_nvm_seq.sv
/*
 * msc_nvm_seq: holds busy for a save or load until the nvm port acknowledges.
 * assumes: nvm_done comes from logic on the same clock.
 */
`timescale 1ns/1ps
module msc_nvm_seq (
    input wire logic clk, // clock
    input wire logic srst, // sync reset, high
    msc_nvm_if.seq nv, // bank side
    input wire logic nvm_done // nvm operation finished
);
    logic sv_ff, ld_ff, nxt_sv, nxt_ld;
    // ----------------------------------------------------------
    // busy flags; the done pulse wins only over an old request
    // ----------------------------------------------------------
    always_comb begin
        nxt_sv = sv_ff;
        nxt_ld = ld_ff;
        if (nvm_done) begin
            nxt_sv = 1'b0;
            nxt_ld = 1'b0;
        end
        if (nv.save_req) begin
            nxt_sv = 1'b1;
        end
        if (nv.load_req) begin
            nxt_ld = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            sv_ff <= 1'b0;
            ld_ff <= 1'b0;
        end else begin
            sv_ff <= nxt_sv;
            ld_ff <= nxt_ld;
        end
    end
    assign nv.busy_save = sv_ff;
    assign nv.busy_load = ld_ff;
endmodule // msc_nvm_seq

// ### logic/msc_angle_sel.sv
/*
 * msc_angle_sel: chooses and wraps the forced align angle.
 * assumes: configured angle already below 360.
 */
`timescale 1ns/1ps
module msc_angle_sel (
    input wire logic [8:0] host_deg, // angle from control word
    input wire logic [8:0] cfg_deg, // configured align angle
    input wire logic src_sel, // 1 selects the control word
    output logic [8:0] deg_out // applied angle
);
    logic [8:0] wrapped; // host angle modulo 360
    // ----------------------------------------------------------
    // 9 bits reach 511, so one subtraction is enough
    // ----------------------------------------------------------
    always_comb begin
        wrapped = (host_deg >= msc_pkg::DEG_360) ? host_deg - msc_pkg::DEG_360 : host_deg; // [R13]
        deg_out = src_sel ? wrapped : cfg_deg; // [R18]
    end
endmodule // msc_angle_sel

// ### verification/msc_regs_properties.sv
/* msc_regs_properties: port-level checks of the register bank.
   assumes: bound to msc_regs, one clock, srst synchronous active high. */
`timescale 1ns/1ps
module msc_regs_properties (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_idx, // index
    input wire logic [31:0] reg_wdata, // write data
    input wire logic [31:0] reg_rdata, // read data
    input wire logic [15:0] applied_voltage_magnitude, // voltage
    input wire logic [11:0] duty_command, // speed cmd
    input wire logic init_complete_flag, // copy done
    input wire logic host_control_ready_flag, // host may drive
    input wire logic align_hold_en, // hold align
    input wire logic align_startup, // align startup
    input wire logic align_done, // align elapsed
    input wire logic nvm_save_busy, // save busy
    input wire logic nvm_load_busy, // load busy
    input wire logic fault_clear, // clear pulse
    input wire logic retry_count_clear, // retry pulse
    input wire logic [8:0] align_deg, // applied angle
    input wire logic align_exit // leave align
);
    // ----------------------------------------------------------
    // decoded host strobes
    // ----------------------------------------------------------
    logic rd_st; // status word read
    logic wr_ctl; // control word write
    assign rd_st = reg_rd && reg_idx == msc_pkg::IDX_SYS_STATUS;
    assign wr_ctl = reg_wr && reg_idx == msc_pkg::IDX_DEV_CTRL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // status passes a shadow stage, so read data is two samples old
    AST_VOLT: assert property (rd_st |=>
        reg_rdata[31:16] == $past(applied_voltage_magnitude, 2)) else $error("voltage wrong");
    AST_FLAGS: assert property (rd_st |=> reg_rdata[15:0] ==
        {$past(duty_command, 2), $past(init_complete_flag, 2),
        $past(host_control_ready_flag, 2), 2'h0}) else $error("flags");
    AST_SAVE: assert property (wr_ctl && reg_wdata[31] |=> nvm_save_busy)
        else $error("save not started");
    AST_LOAD: assert property (wr_ctl && reg_wdata[30] |=> nvm_load_busy)
        else $error("load not started");
    AST_FLT_CLR: assert property (fault_clear == $past(wr_ctl && reg_wdata[29]))
        else $error("fault clear pulse wrong");
    AST_RETRY: assert property (retry_count_clear == $past(wr_ctl && reg_wdata[28]))
        else $error("retry clear pulse wrong");
    AST_WRAP: assert property (align_deg < msc_pkg::DEG_360)
        else $error("angle not wrapped");
    AST_HOLD: assert property (align_exit ==
        (align_done && !(align_hold_en && align_startup))) else $error("align exit wrong");
    cover property (rd_st);
    cover property (wr_ctl && reg_wdata[29]);
    cover property (nvm_save_busy ##1 !nvm_save_busy);
endmodule // msc_regs_properties
bind msc_regs msc_regs_properties u_props (.clk, .srst, .reg_wr, .reg_rd, .reg_idx, .reg_wdata,
    .reg_rdata, .applied_voltage_magnitude, .duty_command, .init_complete_flag,
    .host_control_ready_flag, .align_hold_en, .align_startup, .align_done, .nvm_save_busy,
    .nvm_load_busy, .fault_clear, .retry_count_clear, .align_deg, .align_exit);

// ### verification/msc_host_model.sv
/* msc_host_model: serial front end of the host, one word per access.
   assumes: bank takes strobes on the rising edge, read data one cycle on. */
`timescale 1ns/1ps
module msc_host_model (
    input wire logic clk, // clock
    input wire logic [31:0] reg_rdata, // read data
    input wire logic reg_rvalid, // read valid
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [7:0] reg_idx, // index
    output logic [31:0] reg_wdata // write data
);
    initial {reg_wr, reg_rd, reg_idx, reg_wdata} = '0;
    // released lines show inverted leftovers so stale values never look valid
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_idx, reg_wdata} <= {1'h1, i, d};
        @(posedge clk);
        {reg_wr, reg_idx, reg_wdata} <= {1'h0, ~i, ~d};
    endtask
    // the answer is fixed at one cycle, so it is sampled just past that edge
    task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic ok);
        @(posedge clk);
        {reg_rd, reg_idx} <= {1'h1, i};
        @(posedge clk);
        {reg_rd, reg_idx} <= {1'h0, ~i};
        #1;
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule // msc_host_model

// ### verification/motor_status_control_regs_tb.sv
/* motor_status_control_regs_tb: directed checks of the register bank.
   assumes: 100 MHz clock, the host model owns the register port. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("ERROR at %0t: got %0h expected %0h", $time, (a), (e)); end end
module motor_status_control_regs_tb;
    logic clk, srst, init_complete_flag, host_control_ready_flag, serial_mode, nvm_done; // drive
    logic align_angle_source_select, align_hold_en, align_startup, align_done; // align inputs
    logic [15:0] applied_voltage_magnitude; // voltage
    logic [11:0] duty_command; // speed cmd
    logic [7:0] meas_resistance, measured_backemf_constant, meas_inductance, reg_idx; // bytes
    logic [3:0] meas_status, meas_pwm_frequency; // measurement status
    logic [23:0] host_watchdog_interval; // watchdog cycles
    logic [8:0] cfg_align_deg, align_deg; // angles
    logic [31:0] reg_wdata, reg_rdata; // bus data
    logic reg_wr, reg_rd, reg_rvalid, nvm_save_busy, nvm_load_busy, fault_clear; // bus, busy
    logic retry_count_clear, align_exit, watchdog_fault; // outputs
    int failures, samples_checked; // counters
    msc_regs #(.WDOG_W(24)) u_dut (.clk, .srst, .reg_wr, .reg_rd, .reg_idx, .reg_wdata, .reg_rdata,
        .reg_rvalid, .applied_voltage_magnitude, .duty_command, .init_complete_flag,
        .host_control_ready_flag, .meas_resistance, .measured_backemf_constant, .meas_inductance,
        .meas_status, .meas_pwm_frequency, .host_watchdog_interval, .serial_mode, .nvm_done,
        .cfg_align_deg, .align_angle_source_select, .align_hold_en, .align_startup, .align_done,
        .nvm_save_busy, .nvm_load_busy, .fault_clear, .retry_count_clear, .align_deg, .align_exit,
        .watchdog_fault);
    msc_host_model u_host (.clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_idx, .reg_wdata);
    always #5 clk = ~clk;
    task automatic rdchk(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] d;
        logic ok;
        u_host.rd(i, d, ok);
        `CHK({ok, d}, {1'h1, e})
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset();
        rdchk(msc_pkg::IDX_SYS_STATUS, 32'h00000000);
        rdchk(msc_pkg::IDX_MOTOR_PARAMS, 32'h00000000);
        rdchk(msc_pkg::IDX_MEAS_STATUS, 32'h00000000);
        rdchk(msc_pkg::IDX_DEV_CTRL, 32'h00000000);
        rdchk(8'h10, 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_status();
        @(posedge clk);
        {applied_voltage_magnitude, duty_command, init_complete_flag, host_control_ready_flag,
            meas_resistance, measured_backemf_constant, meas_inductance, meas_status,
            meas_pwm_frequency} <= {16'hA5C3, 12'h9E1, 2'h3, 24'h3C5A96, 8'hA7};
        repeat (2) @(posedge clk);
        u_host.wr(msc_pkg::IDX_SYS_STATUS, 32'hFFFFFFFF);
        u_host.wr(msc_pkg::IDX_MOTOR_PARAMS, 32'hFFFFFFFF);
        rdchk(msc_pkg::IDX_SYS_STATUS, 32'hA5C39E1C);
        rdchk(msc_pkg::IDX_MOTOR_PARAMS, 32'h3C5A9600);
        rdchk(msc_pkg::IDX_MEAS_STATUS, 32'hA7000000);
        $display("test status done");
    endtask
    task automatic t_ctrl();
        logic [8:0] ang [2];
        logic [8:0] exp_deg [2];
        ang = '{9'h1FF, 9'h168};
        exp_deg = '{9'h097, 9'h000};
        @(posedge clk);
        align_angle_source_select <= 1'h1;
        for (int k = 0; k < 2; k++) begin
            u_host.wr(msc_pkg::IDX_DEV_CTRL, {4'h3, 8'hFF, ang[k], 11'h7FF});
            #1;
            `CHK({fault_clear, retry_count_clear}, 2'h3)
            `CHK(align_deg, exp_deg[k])
            @(posedge clk);
            #1;
            `CHK({fault_clear, retry_count_clear}, 2'h0)
            rdchk(msc_pkg::IDX_DEV_CTRL, 32'h00000000);
        end
        @(posedge clk);
        align_angle_source_select <= 1'h0;
        #1;
        `CHK(align_deg, 9'h05A)
        $display("test control done");
    endtask
    task automatic t_nvm();
        for (int b = 30; b < 32; b++) begin
            u_host.wr(msc_pkg::IDX_DEV_CTRL, 32'h00000001 << b);
            #1;
            `CHK({nvm_save_busy, nvm_load_busy}, (b == 31) ? 2'h2 : 2'h1)
            rdchk(msc_pkg::IDX_DEV_CTRL, 32'h00000001 << b);
            // done is raised on an edge, so the bank sees it one edge later
            @(posedge clk);
            nvm_done <= 1'h1;
            @(posedge clk);
            nvm_done <= 1'h0;
            @(posedge clk);
            #1;
            `CHK({nvm_save_busy, nvm_load_busy}, 2'h0)
        end
        $display("test nvm done");
    endtask
    task automatic t_wdog();
        int n;
        n = 0;
        @(posedge clk);
        {serial_mode, host_watchdog_interval} <= {1'h1, 24'h000008};
        repeat (4) u_host.wr(msc_pkg::IDX_DEV_CTRL, 32'h00000400);
        #1;
        `CHK(watchdog_fault, 1'h0)
        // bounded wait; the kick bit stands one cycle, then 8 idle cycles run out
        while (n < 20 && watchdog_fault !== 1'h1) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(watchdog_fault, 1'h1)
        `CHK(n, 32'h00000009)
        // a timeout has already counted a mismatch; skip what depends on the fault
        if (watchdog_fault === 1'h1) begin
            rdchk(msc_pkg::IDX_CTRL_FAULT, 32'h00000008);
            u_host.wr(msc_pkg::IDX_DEV_CTRL, 32'h20000400);
            repeat (2) @(posedge clk);
            #1;
            `CHK(watchdog_fault, 1'h0)
        end
        @(posedge clk);
        serial_mode <= 1'h0;
        $display("test watchdog done");
    endtask
    task automatic t_align();
        @(posedge clk);
        {align_hold_en, align_startup, align_done} <= 3'h7;
        @(posedge clk);
        #1;
        `CHK(align_exit, 1'h0)
        @(posedge clk);
        align_hold_en <= 1'h0;
        #1;
        `CHK(align_exit, 1'h1)
        $display("test align done");
    endtask
    initial begin
        {clk, srst, nvm_done, serial_mode, align_hold_en, align_startup, align_done} = 7'h20;
        {init_complete_flag, host_control_ready_flag, align_angle_source_select} = 3'h0;
        {applied_voltage_magnitude, duty_command, meas_resistance, measured_backemf_constant,
            meas_inductance, meas_status, meas_pwm_frequency, host_watchdog_interval} = '0;
        cfg_align_deg = 9'h05A;
        {failures, samples_checked} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        t_reset();
        t_status();
        t_ctrl();
        t_nvm();
        t_wdog();
        t_align();
        report_and_stop();
    end
endmodule // motor_status_control_regs_tb
